// ==== design/ctsa_supervision.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ctsa_map.vh"

//Behaviour
// - every comparison picks up at its limit and releases at 97 or 103 percent
// - one high and one low limit shared by all three phase magnitudes
// - thresholds and delay are live inputs, taken while the function runs
// - any phase above the upper limit stops activation; default 1.20 nominal
// - at least one phase above the lower limit is needed; default 0.10 nominal
// - minimum over maximum phase ratio must be below setting, default 10.00 percent
// - negative over positive sequence ratio must exceed setting, default 49.00 percent
// - with residual selected, summed versus residual difference must exceed the limit
// - alarm follows activation after a delay in 5 ms steps, default 0.5 s
// - the summed versus residual magnitude difference is readable, 0.01 nominal units
// - the summed versus residual angle difference is readable, within plus-minus 360 deg
// - the blocking input is sampled once at the start of every cycle
// - pick-up without blocking raises started and begins alarm timing
// - pick-up with blocking raises blocked and nothing else
// - blocking after start clears started and resets timing as a normal release
// - only a definite-time alarm delay exists
// - the operating mode is readable while per-node mode setting is enabled
// - alarm only when all enabled conditions held throughout the delay
// - residual input is unused, first or second channel, added or subtracted
// - magnitude inputs are taken on a fixed 5 ms time base
module ctsa_supervision #(
    parameter [31:0] TIME_BASE_CYCLES = `CTSA_TIME_BASE_CYCLES
) (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // phase fundamental magnitudes, 0.01 x nominal
    input wire [15:0] phase_mag_a,
    input wire [15:0] phase_mag_b,
    input wire [15:0] phase_mag_c,
    // sequence magnitudes from the front end
    input wire [15:0] pos_seq_mag,
    input wire [15:0] neg_seq_mag,
    // summed phase current, magnitude and angle (0.01 deg, 0 to 35999)
    input wire [15:0] sum_mag,
    input wire [15:0] sum_ang,
    // residual channels
    input wire [15:0] first_residual_channel_mag,
    input wire [15:0] first_residual_channel_ang,
    input wire [15:0] second_residual_channel_mag,
    input wire [15:0] second_residual_channel_ang,
    // blocking from the blocking matrix
    input wire block_in,
    // settings
    input wire [15:0] high_limit,
    input wire [15:0] low_limit,
    input wire [15:0] minmax_ratio,
    input wire [15:0] sequence_unbalance_ratio,
    input wire [15:0] residual_current_limit,
    input wire [18:0] definite_delay,
    input wire [1:0] residual_sel,
    input wire residual_subtract,
    input wire per_node_mode_en,
    input wire [2:0] logical_node_mode,
    // status
    output reg cycle_tick,
    output reg started,
    output reg blocked,
    output reg alarm,
    output reg [15:0] measured_diff_mag,
    output reg signed [16:0] measured_diff_ang,
    output reg [2:0] mode_status
);

    // ==========================================================
    // states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_TIMING = 2'h1;
    localparam [1:0] ST_ALARM = 2'h2;
    localparam [1:0] ST_BLOCKED = 2'h3;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [31:0] tick_count;
    reg block_sampled;
    reg [15:0] cur_a;
    reg [15:0] cur_b;
    reg [15:0] cur_c;
    reg [15:0] cur_pos;
    reg [15:0] cur_neg;
    reg [15:0] cur_sum_mag;
    reg [15:0] cur_sum_ang;
    reg [15:0] cur_res_mag;
    reg [15:0] cur_res_ang;
    reg [15:0] min_mag;
    reg [15:0] max_mag;
    reg [15:0] next_diff_mag;
    reg signed [17:0] ang_raw;
    reg signed [17:0] next_diff_ang;
    wire [2:0] over_high;
    wire [2:0] over_low;
    wire ratio_low;
    wire seq_high;
    wire res_high;
    wire res_used;
    wire mode_off;
    wire mode_block;
    wire all_ok;
    wire timer_run;
    wire timer_done;
    wire [47:0] phase_flat;

    // ==========================================================
    // 5 ms time base; inputs are latched once per cycle
    always @(posedge sys_clk) begin
        if (srst) begin
            tick_count <= 32'h00000000;
            cycle_tick <= 1'b0;
        end else if (tick_count >= TIME_BASE_CYCLES - 32'h00000001) begin
            tick_count <= 32'h00000000;
            cycle_tick <= 1'b1;
        end else begin
            tick_count <= tick_count + 32'h00000001;
            cycle_tick <= 1'b0;
        end
    end

    // ==========================================================
    // per-cycle snapshot of measurements and blocking
    always @(posedge sys_clk) begin
        if (srst) begin
            cur_a <= 16'h0000;
            cur_b <= 16'h0000;
            cur_c <= 16'h0000;
            cur_pos <= 16'h0000;
            cur_neg <= 16'h0000;
            cur_sum_mag <= 16'h0000;
            cur_sum_ang <= 16'h0000;
            cur_res_mag <= 16'h0000;
            cur_res_ang <= 16'h0000;
            block_sampled <= 1'b0;
        end else if (cycle_tick) begin
            cur_a <= phase_mag_a;
            cur_b <= phase_mag_b;
            cur_c <= phase_mag_c;
            cur_pos <= pos_seq_mag;
            cur_neg <= neg_seq_mag;
            cur_sum_mag <= sum_mag;
            cur_sum_ang <= sum_ang;
            block_sampled <= block_in;
            case (residual_sel)
                `CTSA_RES_FIRST: begin
                    cur_res_mag <= first_residual_channel_mag;
                    cur_res_ang <= first_residual_channel_ang;
                end
                `CTSA_RES_SECOND: begin
                    cur_res_mag <= second_residual_channel_mag;
                    cur_res_ang <= second_residual_channel_ang;
                end
                default: begin
                    cur_res_mag <= 16'h0000;
                    cur_res_ang <= 16'h0000;
                end
            endcase
        end
    end

    // ==========================================================
    // minimum and maximum of the phases
    always @* begin
        min_mag = (cur_b < cur_a) ? cur_b : cur_a;
        min_mag = (cur_c < min_mag) ? cur_c : min_mag;
        max_mag = (cur_b > cur_a) ? cur_b : cur_a;
        max_mag = (cur_c > max_mag) ? cur_c : max_mag;
    end

    // ==========================================================
    // summed versus residual difference; subtract turns the residual by 180 deg
    always @* begin
        next_diff_mag = (cur_sum_mag >= cur_res_mag) ? (cur_sum_mag - cur_res_mag) :
                        (cur_res_mag - cur_sum_mag);
        ang_raw = $signed({2'b00, cur_sum_ang}) - $signed({2'b00, cur_res_ang});
        if (residual_subtract) begin
            ang_raw = ang_raw - $signed(`CTSA_ANG_HALF);
        end
        if (ang_raw <= -$signed(`CTSA_ANG_FULL)) begin
            next_diff_ang = ang_raw + $signed(`CTSA_ANG_FULL);
        end else begin
            next_diff_ang = ang_raw;
        end
    end

    // ==========================================================
    // comparators; limits are read live so a group change acts at once
    assign phase_flat = {cur_c, cur_b, cur_a};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_phase
            ctsa_hyst_cmp #(
                .OVER(1'b1)
            ) u_high (
                .sys_clk(sys_clk),
                .srst(srst),
                .meas({16'h0000, phase_flat[gi*16 +: 16]}),
                .limit({16'h0000, high_limit}),
                .active(over_high[gi])
            );
            ctsa_hyst_cmp #(
                .OVER(1'b1)
            ) u_low (
                .sys_clk(sys_clk),
                .srst(srst),
                .meas({16'h0000, phase_flat[gi*16 +: 16]}),
                .limit({16'h0000, low_limit}),
                .active(over_low[gi])
            );
        end
    endgenerate

    // ratio tests cross-multiply to avoid a divider
    ctsa_hyst_cmp #(
        .OVER(1'b0)
    ) u_minmax (
        .sys_clk(sys_clk),
        .srst(srst),
        .meas({16'h0000, min_mag} * {16'h0000, `CTSA_RATIO_FULL}),
        .limit({16'h0000, minmax_ratio} * {16'h0000, max_mag}),
        .active(ratio_low)
    );

    ctsa_hyst_cmp #(
        .OVER(1'b1)
    ) u_seq (
        .sys_clk(sys_clk),
        .srst(srst),
        .meas({16'h0000, cur_neg} * {16'h0000, `CTSA_RATIO_FULL}),
        .limit({16'h0000, sequence_unbalance_ratio} * {16'h0000, cur_pos}),
        .active(seq_high)
    );

    ctsa_hyst_cmp #(
        .OVER(1'b1)
    ) u_res (
        .sys_clk(sys_clk),
        .srst(srst),
        .meas({16'h0000, next_diff_mag}),
        .limit({16'h0000, residual_current_limit}),
        .active(res_high)
    );

    // ==========================================================
    // activation: every enabled condition at once
    assign res_used = (residual_sel == `CTSA_RES_FIRST) || (residual_sel == `CTSA_RES_SECOND);
    assign mode_off = per_node_mode_en && (logical_node_mode == `CTSA_MODE_OFF);
    assign mode_block = per_node_mode_en && ((logical_node_mode == `CTSA_MODE_BLOCKED) ||
                        (logical_node_mode == `CTSA_MODE_TEST_BLOCKED));
    assign all_ok = !mode_off &&
                    !(|over_high) &&
                    (|over_low) &&
                    ratio_low &&
                    seq_high &&
                    (!res_used || res_high);

    assign timer_run = (state == ST_TIMING) || (state == ST_ALARM);
    ctsa_delay_timer u_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .tick(cycle_tick),
        .run(timer_run),
        .delay(definite_delay),
        .expired(timer_done)
    );

    // ==========================================================
    // sequence; a block landing in the last 5 ms may come too late
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cycle_tick && all_ok) begin
                    if (block_sampled || mode_block) begin
                        next_state = ST_BLOCKED;
                    end else begin
                        next_state = ST_TIMING;
                    end
                end
            end
            ST_TIMING: begin
                if (!all_ok) begin
                    next_state = ST_IDLE;
                end else if (cycle_tick && (block_sampled || mode_block)) begin
                    next_state = ST_BLOCKED;
                end else if (timer_done) begin
                    next_state = ST_ALARM;
                end
            end
            ST_ALARM: begin
                if (!all_ok) begin
                    next_state = ST_IDLE;
                end else if (cycle_tick && (block_sampled || mode_block)) begin
                    next_state = ST_BLOCKED;
                end
            end
            ST_BLOCKED: begin
                if (!all_ok) begin
                    next_state = ST_IDLE;
                end else if (cycle_tick && !block_sampled && !mode_block) begin
                    next_state = ST_TIMING;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // registered outputs
    always @(posedge sys_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            started <= 1'b0;
            blocked <= 1'b0;
            alarm <= 1'b0;
            measured_diff_mag <= 16'h0000;
            measured_diff_ang <= 17'h00000;
            mode_status <= `CTSA_MODE_ON;
        end else begin
            state <= next_state;
            started <= (next_state == ST_TIMING) || (next_state == ST_ALARM);
            blocked <= (next_state == ST_BLOCKED);
            alarm <= (next_state == ST_ALARM);
            measured_diff_mag <= res_used ? next_diff_mag : 16'h0000;
            measured_diff_ang <= res_used ? next_diff_ang[16:0] : 17'h00000;
            mode_status <= per_node_mode_en ? logical_node_mode : `CTSA_MODE_ON;
        end
    end

endmodule // ctsa_supervision

`default_nettype wire

// ==== include/ctsa_map.vh ====
`ifndef CTSA_MAP_VH
`define CTSA_MAP_VH

// ==========================================================
// clock and time base
`define CTSA_CLK_PERIOD_NS 10
`define CTSA_TIME_BASE_US 5000
`define CTSA_TIME_BASE_CYCLES ((`CTSA_TIME_BASE_US * 1000) / `CTSA_CLK_PERIOD_NS)

// ==========================================================
// hysteresis, percent of the limit
`define CTSA_HYST_SCALE 8'h64
`define CTSA_HYST_LOW 8'h61
`define CTSA_HYST_HIGH 8'h67

// ==========================================================
// ratio scaling: settings in 0.01 %, so 100 % is 10000
`define CTSA_RATIO_FULL 16'h2710

// ==========================================================
// setting reset values (currents in 0.01 x nominal)
`define CTSA_HIGH_LIMIT_RST 16'h0078
`define CTSA_LOW_LIMIT_RST 16'h000a
`define CTSA_MINMAX_RATIO_RST 16'h03e8
`define CTSA_SEQ_RATIO_RST 16'h1324
`define CTSA_RESIDUAL_LIMIT_RST 16'h000a
`define CTSA_DELAY_RST 19'h00064

// ==========================================================
// residual input selection
`define CTSA_RES_NONE 2'h0
`define CTSA_RES_FIRST 2'h1
`define CTSA_RES_SECOND 2'h2

// ==========================================================
// angles in 0.01 degree
`define CTSA_ANG_HALF 18'h04650
`define CTSA_ANG_FULL 18'h08ca0

// ==========================================================
// logical node modes
`define CTSA_MODE_ON 3'h0
`define CTSA_MODE_BLOCKED 3'h1
`define CTSA_MODE_TEST 3'h2
`define CTSA_MODE_TEST_BLOCKED 3'h3
`define CTSA_MODE_OFF 3'h4

`endif

// ==== design/ctsa_hyst_cmp.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ctsa_map.vh"

module ctsa_hyst_cmp #(
    parameter [0:0] OVER = 1'b1
) (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // operands
    input wire [31:0] meas,
    input wire [31:0] limit,
    // result
    output reg active
);

    // ==========================================================
    // scaled operands for the release point
    wire [39:0] meas_scaled;
    wire [39:0] limit_rel;

    assign meas_scaled = {8'h00, meas} * {32'h0, `CTSA_HYST_SCALE};
    assign limit_rel = {8'h00, limit} * {32'h0, (OVER ? `CTSA_HYST_LOW : `CTSA_HYST_HIGH)};

    // ==========================================================
    // picks up at the limit, releases at 97 or 103 percent of it
    always @(posedge sys_clk) begin
        if (srst) begin
            active <= 1'b0;
        end else if (active) begin
            active <= OVER ? (meas_scaled >= limit_rel) : (meas_scaled <= limit_rel);
        end else begin
            active <= OVER ? (meas > limit) : (meas < limit);
        end
    end

endmodule // ctsa_hyst_cmp

`default_nettype wire

// ==== design/ctsa_delay_timer.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ctsa_map.vh"

module ctsa_delay_timer (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // control
    input wire tick,
    input wire run,
    input wire [18:0] delay,
    // status
    output wire expired
);

    reg [18:0] count;

    // ==========================================================
    // definite time only; stopping the run clears the count
    always @(posedge sys_clk) begin
        if (srst) begin
            count <= 19'h00000;
        end else if (!run) begin
            count <= 19'h00000;
        end else if (tick && count < delay) begin
            count <= count + 19'h00001;
        end
    end

    assign expired = run && (count >= delay);

endmodule // ctsa_delay_timer

`default_nettype wire

// ==== testbench/ctsa_supervision_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
// ====================================================
// checker on the supervision ports
module ctsa_supervision_assertions #(
    parameter [31:0] TIME_BASE_CYCLES = 32'h8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // inputs watched
    input wire logic block_in,
    input wire logic [18:0] definite_delay,
    input wire logic per_node_mode_en,
    input wire logic [2:0] logical_node_mode,
    // outputs watched
    input wire logic cycle_tick,
    input wire logic started,
    input wire logic blocked,
    input wire logic alarm,
    input wire logic [2:0] mode_status
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // ====================================================
    // helper counters, cleared by reset so a mid-run reset starts afresh
    logic [31:0] gap;
    logic seen;
    logic [18:0] held;
    always @(posedge sys_clk) begin
        if (srst) begin
            gap <= 32'h0;
            seen <= 1'b0;
        end else if (cycle_tick) begin
            gap <= 32'h0;
            seen <= 1'b1;
        end else begin
            gap <= gap + 32'h1;
        end
    end
    always @(posedge sys_clk) begin
        if (srst || !started) begin
            held <= 19'h0;
        end else if (cycle_tick) begin
            held <= held + 19'h1;
        end
    end
    // ====================================================
    // sequences and assertions
    sequence s_block_taken;
        cycle_tick && block_in ##1 block_in [*8];
    endsequence
    sequence s_pickup;
        !started ##1 started;
    endsequence
    a_tick_period: assert property (cycle_tick && seen |-> gap == TIME_BASE_CYCLES - 32'h1)
        else $error("tick spacing wrong");
    a_tick_single: assert property (cycle_tick |=> !cycle_tick)
        else $error("tick longer than one cycle");
    a_block_quiet: assert property (blocked |-> !started && !alarm
        && ($past(blocked) || $past(cycle_tick))) else $error("blocked wrongly or off tick");
    a_alarm_started: assert property (alarm |-> started
        && ($past(alarm) || $past(started))) else $error("alarm without start");
    a_start_on_tick: assert property (s_pickup |-> $past(cycle_tick, 1) || $past(cycle_tick, 2)
        || $past(cycle_tick, 3)) else $error("start not tied to a tick");
    a_alarm_delay: assert property ($rose(alarm) |-> held >= definite_delay)
        else $error("alarm before delay");
    a_alarm_not_early: assert property (s_pickup ##0 definite_delay != 19'h0 |-> !alarm)
        else $error("alarm together with start");
    a_block_clears: assert property (s_block_taken |-> ##[0:12] (!started && !alarm))
        else $error("block did not clear start");
    a_mode_shown: assert property (!$past(srst) && $past(per_node_mode_en)
        |-> mode_status == $past(logical_node_mode)) else $error("mode not shown");
    a_mode_hidden: assert property (!$past(srst) && !$past(per_node_mode_en)
        |-> mode_status == 3'h0) else $error("mode shown while disabled");
endmodule // ctsa_supervision_assertions
`default_nettype wire

// ==== testbench/ctsa_front_end.sv ====
`timescale 1ns/10ps
`default_nettype none
// ====================================================
// measurement front end, one frame per time base
module ctsa_front_end (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // time base and case select
    input wire logic cycle_tick,
    input wire logic [2:0] case_sel,
    // measurements
    output logic [15:0] phase_mag_a,
    output logic [15:0] phase_mag_b,
    output logic [15:0] phase_mag_c,
    output logic [15:0] pos_seq_mag,
    output logic [15:0] neg_seq_mag,
    output logic [15:0] sum_mag,
    output logic [15:0] sum_ang,
    output logic [15:0] first_residual_channel_mag,
    output logic [15:0] first_residual_channel_ang,
    output logic [15:0] second_residual_channel_mag,
    output logic [15:0] second_residual_channel_ang
);
    logic [127:0] frame;
    assign {phase_mag_a, phase_mag_b, phase_mag_c, pos_seq_mag, neg_seq_mag, sum_mag,
        first_residual_channel_mag, second_residual_channel_mag} = frame;
    assign sum_ang = 16'h0000;
    assign first_residual_channel_ang = 16'h0000;
    assign second_residual_channel_ang = 16'h2328;
    // new frame only at a tick, never between, as a real time base would
    always @(negedge sys_clk) begin
        if (srst) begin
            frame <= {{4{16'h0064}}, 64'h0};
        end else if (cycle_tick) begin
            case (case_sel)
                3'h1: frame <= {16'h0, 16'h64, 16'h64, 16'h43, 16'h21, 16'h64, 32'h0};
                3'h2: frame <= {16'h0, 16'h82, 16'h64, 16'h4d, 16'h28, 16'h64, 32'h0};
                3'h3: frame <= {16'h0, 16'h5, 16'h5, 16'h3, 16'h2, 16'h5, 32'h0};
                3'h4: frame <= {16'h0, 16'h64, 16'h64, 16'h43, 16'h21, 16'h64, 16'h64, 16'h0};
                default: frame <= {{4{16'h0064}}, 64'h0};
            endcase
        end
    end
endmodule // ctsa_front_end
`default_nettype wire

// ==== testbench/ctsa_supervision_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ctsa_map.vh"
// ====================================================
// supervision bench
module ctsa_supervision_test;
    localparam int TB = 8;
    logic sys_clk, srst, block_in, residual_subtract, per_node_mode_en;
    logic [2:0] case_sel, logical_node_mode;
    logic [15:0] high_limit, low_limit, minmax_ratio, sequence_unbalance_ratio;
    logic [15:0] residual_current_limit;
    logic [18:0] definite_delay;
    logic [1:0] residual_sel;
    wire logic [15:0] mag_a, mag_b, mag_c, pos_m, neg_m, sum_m, sum_a, r1_m, r1_a, r2_m, r2_a;
    wire logic cycle_tick, started, blocked, alarm;
    wire logic [15:0] diff_mag;
    wire logic signed [16:0] diff_ang;
    wire logic [2:0] mode_status;
    int err_count, check_count, last_wait, e, i;
    ctsa_supervision #(.TIME_BASE_CYCLES(TB)) ctsa_supervision_i (
        .sys_clk(sys_clk), .srst(srst), .phase_mag_a(mag_a), .phase_mag_b(mag_b),
        .phase_mag_c(mag_c), .pos_seq_mag(pos_m), .neg_seq_mag(neg_m), .sum_mag(sum_m),
        .sum_ang(sum_a), .first_residual_channel_mag(r1_m), .first_residual_channel_ang(r1_a),
        .second_residual_channel_mag(r2_m), .second_residual_channel_ang(r2_a),
        .block_in(block_in), .high_limit(high_limit), .low_limit(low_limit),
        .minmax_ratio(minmax_ratio), .sequence_unbalance_ratio(sequence_unbalance_ratio),
        .residual_current_limit(residual_current_limit), .definite_delay(definite_delay),
        .residual_sel(residual_sel), .residual_subtract(residual_subtract),
        .per_node_mode_en(per_node_mode_en), .logical_node_mode(logical_node_mode),
        .cycle_tick(cycle_tick), .started(started), .blocked(blocked), .alarm(alarm),
        .measured_diff_mag(diff_mag), .measured_diff_ang(diff_ang), .mode_status(mode_status)
    );
    ctsa_front_end ctsa_front_end_i (
        .sys_clk(sys_clk), .srst(srst), .cycle_tick(cycle_tick), .case_sel(case_sel),
        .phase_mag_a(mag_a), .phase_mag_b(mag_b), .phase_mag_c(mag_c), .pos_seq_mag(pos_m),
        .neg_seq_mag(neg_m), .sum_mag(sum_m), .sum_ang(sum_a),
        .first_residual_channel_mag(r1_m), .first_residual_channel_ang(r1_a),
        .second_residual_channel_mag(r2_m), .second_residual_channel_ang(r2_a)
    );
    always #5 sys_clk = ~sys_clk;
    // ====================================================
    // tasks
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // bounded wait on started (0), alarm (1) or blocked (2)
    task automatic wait_for(input int sel, input logic v, input int lim);
        logic s;
        s = ~v;
        last_wait = 0;
        while (s !== v && last_wait < lim) begin
            @(negedge sys_clk);
            last_wait++;
            s = (sel == 0) ? started : (sel == 1) ? alarm : blocked;
        end
        chk({31'h0, s}, {31'h0, v});
    endtask
    task automatic try_case(input logic [2:0] c, input logic [1:0] sel, input logic exp);
        case_sel = c;
        residual_sel = sel;
        idle(5 * TB);
        chk({31'h0, started}, {31'h0, exp});
        case_sel = 3'h0;
        residual_sel = 2'h0;
        wait_for(0, 1'b0, 5 * TB);
    endtask
    // ====================================================
    // main sequence
    initial begin
        sys_clk = 1'b0;
        srst = 1'b1;
        case_sel = 3'h0;
        block_in = 1'b0;
        high_limit = `CTSA_HIGH_LIMIT_RST;
        low_limit = `CTSA_LOW_LIMIT_RST;
        minmax_ratio = `CTSA_MINMAX_RATIO_RST;
        sequence_unbalance_ratio = `CTSA_SEQ_RATIO_RST;
        residual_current_limit = `CTSA_RESIDUAL_LIMIT_RST;
        definite_delay = 19'h3;
        residual_sel = 2'h0;
        residual_subtract = 1'b0;
        per_node_mode_en = 1'b0;
        logical_node_mode = 3'h0;
        idle(4);
        srst = 1'b0;
        idle(1);
        chk({13'h0, started, blocked, alarm, diff_mag}, 32'h0);
        case_sel = 3'h1;
        wait_for(0, 1'b1, 4 * TB);
        chk({31'h0, alarm}, 32'h0);
        wait_for(1, 1'b1, 6 * TB);
        chk({31'h0, last_wait >= 22 && last_wait <= 26}, 32'h1);
        high_limit = 16'h0063;
        wait_for(0, 1'b0, 4);
        chk({31'h0, alarm}, 32'h0);
        high_limit = 16'h0066;
        idle(3 * TB);
        chk({31'h0, started}, 32'h0);
        high_limit = 16'h0068;
        wait_for(0, 1'b1, 3 * TB);
        high_limit = `CTSA_HIGH_LIMIT_RST;
        block_in = 1'b1;
        wait_for(2, 1'b1, 3 * TB);
        chk({30'h0, started, alarm}, 32'h0);
        block_in = 1'b0;
        wait_for(0, 1'b1, 3 * TB);
        chk({31'h0, blocked}, 32'h0);
        wait_for(1, 1'b1, 6 * TB);
        chk({31'h0, last_wait >= 22 && last_wait <= 26}, 32'h1);
        case_sel = 3'h0;
        wait_for(0, 1'b0, 3 * TB);
        chk({31'h0, alarm}, 32'h0);
        block_in = 1'b1;
        case_sel = 3'h1;
        wait_for(2, 1'b1, 4 * TB);
        idle(4 * TB);
        chk({31'h0, started}, 32'h0);
        block_in = 1'b0;
        case_sel = 3'h0;
        wait_for(2, 1'b0, 4 * TB);
        per_node_mode_en = 1'b1;
        logical_node_mode = `CTSA_MODE_OFF;
        try_case(3'h1, 2'h0, 1'b0);
        per_node_mode_en = 1'b0;
        try_case(3'h2, 2'h0, 1'b0);
        try_case(3'h3, 2'h0, 1'b0);
        try_case(3'h4, 2'h1, 1'b0);
        try_case(3'h4, 2'h0, 1'b1);
        try_case(3'h4, 2'h2, 1'b1);
        case_sel = 3'h4;
        residual_sel = 2'h2;
        for (i = 0; i < 2; i++) begin
            residual_subtract = i[0];
            idle(3 * TB);
            e = -9000 - (i * 18000);
            chk({16'h0, diff_mag}, 32'h64);
            chk({15'h0, diff_ang}, {15'h0, e[16:0]});
        end
        residual_sel = 2'h0;
        case_sel = 3'h0;
        idle(3 * TB);
        chk({16'h0, diff_mag}, 32'h0);
        per_node_mode_en = 1'b1;
        for (i = 0; i < 5; i++) begin
            logical_node_mode = i[2:0];
            idle(2);
            chk({29'h0, mode_status}, {29'h0, i[2:0]});
        end
        per_node_mode_en = 1'b0;
        idle(2);
        chk({29'h0, mode_status}, 32'h0);
        summarize();
    end
    // watchdog, far beyond the expected run length
    initial begin
        #(3000 * TB * 10);
        err_count++;
        summarize();
    end
endmodule // ctsa_supervision_test
bind ctsa_supervision ctsa_supervision_assertions #(.TIME_BASE_CYCLES(TIME_BASE_CYCLES))
    ctsa_supervision_assertions_i (
    .sys_clk(sys_clk), .srst(srst), .block_in(block_in), .definite_delay(definite_delay),
    .per_node_mode_en(per_node_mode_en), .logical_node_mode(logical_node_mode),
    .cycle_tick(cycle_tick), .started(started), .blocked(blocked), .alarm(alarm),
    .mode_status(mode_status)
);
`default_nettype wire
